// ===== verilog/qub_regs.svh
`ifndef QUB_REGS_SVH
`define QUB_REGS_SVH
// ---------------------------------------------------------------
// per-channel register offsets (low three address bits)
// ---------------------------------------------------------------
`define QUB_OFF_IER 3'h1
`define QUB_OFF_IIR 3'h2
`define QUB_OFF_MCR 3'h4
`define QUB_OFF_MSR 3'h6
`define QUB_OFF_SPR 3'h7
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define QUB_MCR_RTS 1
`define QUB_MCR_OUT2 3
`define QUB_MCR_AFE 5
`define QUB_IER_MS 3
`define QUB_MSR_TERI 2
`define QUB_MSR_RI 6
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define QUB_MCR_RST 8'h00
`define QUB_IER_RST 8'h00
`define QUB_SPR_RST 8'hff
`define QUB_IIR_NONE 8'h01
`define QUB_IIR_MODEM 8'h00
`endif

// ===== verilog/qub_pkg.sv
package qub_pkg;
    // bus side signals sampled from the host pins
    typedef struct packed {
        logic cs_n;
        logic [4:0] addr;
        logic [7:0] wdata;
    } qub_bus_t;
    typedef enum logic [1:0] {QUB_IDLE = 2'b00, QUB_ACT = 2'b01} qub_acc_t;
endpackage : qub_pkg

// ===== verilog/qub_sync_edge.sv
// ---------------------------------------------------------------
// two-flop synchroniser with edge detect on the synced level
// ---------------------------------------------------------------
module qub_sync_edge #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic sys_clk, // clock
    input wire logic srst, // sync reset, active high
    input wire logic [W-1:0] din, // async level
    output logic [W-1:0] level, // synced level
    output logic [W-1:0] rise, // one-cycle rise pulse
    output logic [W-1:0] fall // one-cycle fall pulse
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    // first flop feeds only the second
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign level = s2_r;
    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;
endmodule : qub_sync_edge

// ===== verilog/qub_host_if.sv
`include "qub_regs.svh"
module qub_host_if #(
    parameter int NCH = 4
) (
    input wire logic sys_clk, // system clock, 50 MHz
    input wire logic srst, // synchronous system reset, active high
    input wire logic mode_sel, // 1 separate strobes, 0 combined strobe
    input wire logic reset_pin, // device reset pin, polarity per mode
    input wire logic cs_n, // chip select, active low
    input wire logic [4:0] addr, // address bus
    input wire logic [7:0] data_in, // data bus in
    input wire logic read_strobe_n, // read strobe (separate style)
    input wire logic write_strobe_n, // write strobe or read/write direction
    input wire logic [NCH-1:0] ring_indicate_n, // ring indicate per channel, active low
    input wire logic [NCH-1:0] rts_auto_req_n, // auto flow request from receive side
    output logic [7:0] data_out, // data bus out
    output logic data_oe, // data bus drive enable
    output logic irq_n, // shared active-low request / channel A in separate style
    output logic [NCH-1:0] chan_irq, // per-channel interrupt outputs
    output logic [NCH-1:0] chan_irq_oe, // per-channel output enables
    output logic [NCH-1:0] rts_n, // request to send, active low
    output logic [NCH-1:0] serial_en, // transmit/receive enable per channel
    output logic [NCH-1:0] auto_flow // automatic flow control enabled
);
    // channel select is two address bits wide, so only four channels can be served
    generate
        if (NCH != 4)
        begin : g_nch_check
            $error("qub_host_if serves four channels only");
        end
    endgenerate
    // ---------------------------------------------------------------
    // synchronisers
    // ---------------------------------------------------------------
    logic rd_fall, wr_lvl, wr_fall;
    logic cs_rise;
    logic [NCH-1:0] ri_rise;
    qub_sync_edge #(.W(1), .INIT(1'b1)) u_rd (.sys_clk(sys_clk), .srst(srst), .din(read_strobe_n),
        .level(), .rise(), .fall(rd_fall));
    qub_sync_edge #(.W(1), .INIT(1'b1)) u_wr (.sys_clk(sys_clk), .srst(srst), .din(write_strobe_n),
        .level(wr_lvl), .rise(), .fall(wr_fall));
    qub_sync_edge #(.W(1), .INIT(1'b0)) u_cs (.sys_clk(sys_clk), .srst(srst), .din(~cs_n),
        .level(), .rise(cs_rise), .fall());
    qub_sync_edge #(.W(NCH), .INIT('1)) u_ri (.sys_clk(sys_clk), .srst(srst), .din(ring_indicate_n),
        .level(), .rise(ri_rise), .fall());
    // ---------------------------------------------------------------
    // reset and access decode
    // ---------------------------------------------------------------
    logic sep_mode;
    logic dev_rst;
    qub_pkg::qub_bus_t bus;
    logic wr_ev, rd_ev;
    logic [1:0] ch_sel;
    assign sep_mode = mode_sel;
    // reset pin is active high in separate style, active low in combined
    assign dev_rst = srst | (sep_mode ? reset_pin : ~reset_pin);
    assign bus = '{cs_n: cs_n, addr: addr, wdata: data_in};
    // combined style takes access on chip select assertion, direction from the write pin
    assign wr_ev = sep_mode ? (wr_fall & ~bus.cs_n) : (cs_rise & ~wr_lvl);
    assign rd_ev = sep_mode ? (rd_fall & ~bus.cs_n) : (cs_rise & wr_lvl);
    // separate style reaches channel A only through the low three bits
    assign ch_sel = sep_mode ? 2'h0 : bus.addr[4:3];
    function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
        hit = (a == off);
    endfunction : hit
    // ---------------------------------------------------------------
    // per-channel registers
    // ---------------------------------------------------------------
    logic [7:0] mcr_r [NCH];
    logic [7:0] ier_r [NCH];
    logic [7:0] spr_r [NCH];
    logic [NCH-1:0] teri_r;
    logic [NCH-1:0] cond;
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            logic sel;
            assign sel = (ch_sel == 2'(g));
            // register writes
            always_ff @(posedge sys_clk)
            begin
                if (dev_rst)
                begin
                    mcr_r[g] <= `QUB_MCR_RST;
                    ier_r[g] <= `QUB_IER_RST;
                    spr_r[g] <= `QUB_SPR_RST;
                end
                else if (wr_ev && sel)
                begin
                    if (hit(bus.addr[2:0], `QUB_OFF_MCR))
                        mcr_r[g] <= bus.wdata;
                    if (hit(bus.addr[2:0], `QUB_OFF_IER))
                        ier_r[g] <= bus.wdata;
                    if (hit(bus.addr[2:0], `QUB_OFF_SPR))
                        spr_r[g] <= bus.wdata;
                end
            end
            // ring edge sets a sticky flag; reading status clears it, set wins
            always_ff @(posedge sys_clk)
            begin
                if (dev_rst)
                    teri_r[g] <= 1'b0;
                else if (ri_rise[g])
                    teri_r[g] <= 1'b1;
                else if (rd_ev && sel && hit(bus.addr[2:0], `QUB_OFF_MSR))
                    teri_r[g] <= 1'b0;
            end
            assign cond[g] = teri_r[g] & ier_r[g][`QUB_IER_MS];
        end
    endgenerate
    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    logic [7:0] rdata;
    always_comb
    begin
        unique case (bus.addr[2:0])
            `QUB_OFF_MCR: rdata = mcr_r[ch_sel];
            `QUB_OFF_IER: rdata = ier_r[ch_sel];
            `QUB_OFF_SPR: rdata = spr_r[ch_sel];
            `QUB_OFF_IIR: rdata = cond[ch_sel] ? `QUB_IIR_MODEM : `QUB_IIR_NONE;
            `QUB_OFF_MSR: rdata = {5'h00, teri_r[ch_sel], 2'h0}; // ring flag at bit 2
            default: rdata = 8'h00;
        endcase
    end
    // data bus is driven while the read strobe or read cycle is active
    always_ff @(posedge sys_clk)
    begin
        if (dev_rst)
        begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end
        else
        begin
            if (rd_ev)
                data_out <= rdata;
            data_oe <= rd_ev | (data_oe & ~cs_n & (sep_mode ? ~read_strobe_n : write_strobe_n));
        end
    end
    // ---------------------------------------------------------------
    // interrupt and modem outputs
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (dev_rst)
        begin
            irq_n <= 1'b1;
            chan_irq <= '0;
            chan_irq_oe <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                chan_irq[i] <= sep_mode & cond[i] & mcr_r[i][`QUB_MCR_OUT2];
                chan_irq_oe[i] <= sep_mode & mcr_r[i][`QUB_MCR_OUT2];
            end
            // combined: OR of all channels; separate: channel A only
            irq_n <= sep_mode ? ~(cond[0] & mcr_r[0][`QUB_MCR_OUT2]) : ~(|cond);
        end
    end
    // rts follows the control bit, and the receive side also holds it high when auto flow is on
    always_ff @(posedge sys_clk)
    begin
        if (dev_rst)
        begin
            rts_n <= '1;
            serial_en <= '0;
            auto_flow <= '0;
        end
        else
        begin
            serial_en <= '1;
            for (int i = 0; i < NCH; i++)
            begin
                auto_flow[i] <= mcr_r[i][`QUB_MCR_AFE];
                rts_n[i] <= ~mcr_r[i][`QUB_MCR_RTS] |
                    (mcr_r[i][`QUB_MCR_AFE] & rts_auto_req_n[i]);
            end
        end
    end
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_rts_reset;
        @(posedge sys_clk) dev_rst |=> (rts_n == '1);
    endproperty
    a_rts_reset: assert property (p_rts_reset) else $error("rts not high after reset");
    property p_ser_off;
        @(posedge sys_clk) dev_rst |=> (serial_en == '0);
    endproperty
    a_ser_off: assert property (p_ser_off) else $error("serial enabled in reset");
    sequence s_ring;
        ri_rise[0] && !dev_rst;
    endsequence
    property p_ring;
        @(posedge sys_clk) disable iff (dev_rst) s_ring |=> teri_r[0];
    endproperty
    a_ring: assert property (p_ring) else $error("ring edge lost");
    property p_irq_comb;
        @(posedge sys_clk) disable iff (dev_rst) (!sep_mode && |cond) |=> !irq_n;
    endproperty
    a_irq_comb: assert property (p_irq_comb) else $error("shared request not low");
    property p_irq_sep;
        @(posedge sys_clk) disable iff (dev_rst)
            (sep_mode && !cond[0]) |=> irq_n;
    endproperty
    a_irq_sep: assert property (p_irq_sep) else $error("channel A request wrong");
    property p_chirq;
        @(posedge sys_clk) disable iff (dev_rst)
            (!mcr_r[1][`QUB_MCR_OUT2]) |=> !chan_irq[1];
    endproperty
    a_chirq: assert property (p_chirq) else $error("channel irq without enable");
    property p_rts_man;
        @(posedge sys_clk) disable iff (dev_rst)
            (mcr_r[2][`QUB_MCR_RTS] && !mcr_r[2][`QUB_MCR_AFE]) |=> !rts_n[2];
    endproperty
    a_rts_man: assert property (p_rts_man) else $error("rts not driven low");
    property p_write;
        @(posedge sys_clk) disable iff (dev_rst)
            (wr_ev && ch_sel == 2'h0 && bus.addr[2:0] == `QUB_OFF_SPR) |=> (spr_r[0] == $past(bus.wdata));
    endproperty
    a_write: assert property (p_write) else $error("write not stored");
    property p_read;
        @(posedge sys_clk) disable iff (dev_rst) rd_ev |=> (data_oe && data_out == $past(rdata));
    endproperty
    a_read: assert property (p_read) else $error("read data not driven");
endmodule : qub_host_if

// ===== bench/qub_host_model.sv
// ---------------------------------------------------------------
// host processor model on the parallel register bus
// ---------------------------------------------------------------
module qub_host_model (
    input wire logic sys_clk, // system clock
    input wire logic mode_sel, // 1 separate strobes, 0 combined strobe
    input wire logic [7:0] data_out, // data bus from the device
    input wire logic data_oe, // device drives the data bus
    output logic cs_n, // chip select, active low
    output logic [4:0] addr, // address bus
    output logic [7:0] data_in, // data bus to the device
    output logic read_strobe_n, // read strobe
    output logic write_strobe_n // write strobe or direction
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus at time zero
    initial
    begin
        cs_n = 1'b1;
        addr = 5'h00;
        data_in = 8'h00;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
    end
    // every change lands a fixed 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    // one byte access; strobes held 6 cycles to clear the 2-cycle sync and the answer edge
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        addr = a;
        data_in = wr ? d : ~data_in; // a read inverts the idle bus, so it drives the byte of the previous access again
        if (mode_sel)
        begin
            cs_n = 1'b0;
            step(1);
            if (wr) write_strobe_n = 1'b0;
            else read_strobe_n = 1'b0;
        end
        else
        begin
            write_strobe_n = ~wr;
            step(1);
            cs_n = 1'b0;
        end
        step(6);
        q = (wr || data_oe === 1'b1) ? data_out : 8'hxx;
        read_strobe_n = 1'b1;
        if (mode_sel) write_strobe_n = 1'b1;
        step(1);
        cs_n = 1'b1;
        data_in = ~data_in;
        step(4);
    endtask : xfer
endmodule : qub_host_model

// ===== bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // ---------------------------------------------------------------
    // stimulus and wiring
    // ---------------------------------------------------------------
    logic sys_clk;
    logic srst;
    logic mode_sel;
    logic reset_pin;
    logic [3:0] ring_indicate_n;
    logic [3:0] rts_auto_req_n;
    logic cs_n, read_strobe_n, write_strobe_n, data_oe, irq_n;
    logic [4:0] addr;
    logic [7:0] data_in, data_out, q;
    logic [3:0] chan_irq, chan_irq_oe, rts_n, serial_en, auto_flow;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #10 sys_clk = ~sys_clk;
    qub_host_model h (.sys_clk(sys_clk), .mode_sel(mode_sel), .data_out(data_out), .data_oe(data_oe),
        .cs_n(cs_n), .addr(addr), .data_in(data_in), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n));
    qub_host_if #(.NCH(4)) dut (.sys_clk(sys_clk), .srst(srst), .mode_sel(mode_sel), .reset_pin(reset_pin),
        .cs_n(cs_n), .addr(addr), .data_in(data_in), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .ring_indicate_n(ring_indicate_n), .rts_auto_req_n(rts_auto_req_n),
        .data_out(data_out), .data_oe(data_oe), .irq_n(irq_n), .chan_irq(chan_irq), .chan_irq_oe(chan_irq_oe),
        .rts_n(rts_n), .serial_en(serial_en), .auto_flow(auto_flow));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        h.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        h.xfer(1'b0, a, 8'h00, q);
    endtask : rd
    // outputs as they must stand while any reset is active
    task automatic chk_idle();
        chk({irq_n, data_oe, rts_n, 2'b00}, 8'hbc);
        chk({serial_en, chan_irq}, 8'h00);
    endtask : chk_idle
    // reset pin pulse at the level the current bus style treats as active
    task automatic pin_reset();
        reset_pin = mode_sel;
        h.step(2);
        chk_idle();
        reset_pin = ~mode_sel;
        h.step(2);
    endtask : pin_reset
    task automatic ring(input int ch);
        ring_indicate_n[ch] = 1'b0;
        h.step(6);
        ring_indicate_n[ch] = 1'b1;
        h.step(6);
    endtask : ring
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        rd(5'h07);
        chk(q, 8'hff);
        rd(5'h04);
        chk(q, 8'h00);
        rd(5'h02);
        chk(q, 8'h01);
        rd(5'h00);
        chk(q, 8'h00);
        chk({4'h0, serial_en}, 8'h0f);
        wr(5'h07, 8'h5a);
        rd(5'h07);
        chk(q, 8'h5a);
        pin_reset();
        rd(5'h07);
        chk(q, 8'hff);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rts();
        wr(5'h04, 8'h02);
        chk({4'h0, rts_n}, 8'h0e);
        rd(5'h04);
        chk(q, 8'h02);
        rts_auto_req_n[0] = 1'b1;
        wr(5'h04, 8'h22);
        chk({auto_flow, rts_n}, 8'h1f);
        rts_auto_req_n[0] = 1'b0;
        h.step(3);
        chk({4'h0, rts_n}, 8'h0e);
        wr(5'h04, 8'h00);
        chk({4'h0, rts_n}, 8'h0f);
        $display("test rts done");
    endtask : t_rts
    task automatic t_ring();
        wr(5'h04, 8'h08);
        wr(5'h01, 8'h08);
        ring_indicate_n[0] = 1'b0;
        h.step(6);
        chk({7'h00, irq_n}, 8'h01);
        ring_indicate_n[0] = 1'b1;
        h.step(6);
        chk({irq_n, chan_irq[0], chan_irq_oe[0]}, 8'h03);
        rd(5'h02);
        chk(q, 8'h00);
        rd(5'h06);
        chk(q & 8'h04, 8'h04);
        chk({7'h00, irq_n}, 8'h01);
        wr(5'h04, 8'h00);
        ring(0);
        chk({irq_n, chan_irq_oe[0]}, 8'h02);
        $display("test ring done");
    endtask : t_ring
    task automatic t_comb();
        mode_sel = 1'b0;
        reset_pin = 1'b1;
        srst = 1'b1;
        h.step(2);
        srst = 1'b0;
        h.step(2);
        pin_reset();
        wr(5'h14, 8'h02);
        chk({4'h0, rts_n}, 8'h0b);
        rd(5'h14);
        chk(q, 8'h02);
        rd(5'h04);
        chk(q, 8'h00);
        wr(5'h19, 8'h08);
        ring(3);
        chk({7'h00, irq_n}, 8'h00);
        rd(5'h02);
        chk(q, 8'h01);
        rd(5'h1a);
        chk(q, 8'h00);
        rd(5'h1e);
        chk(q & 8'h04, 8'h04);
        chk({7'h00, irq_n}, 8'h01);
        $display("test combined done");
    endtask : t_comb
    // ---------------------------------------------------------------
    // main sequence and hang guard
    // ---------------------------------------------------------------
    initial
    begin
        // pin levels start here; apart from sys_clk each one is a stimulus the scenarios move
        sys_clk = 1'b0;
        srst = 1'b1;
        mode_sel = 1'b1;
        reset_pin = 1'b0;
        ring_indicate_n = 4'hf;
        rts_auto_req_n = 4'h0;
        h.step(3);
        chk_idle();
        h.step(2);
        srst = 1'b0;
        h.step(2);
        t_reset();
        t_rts();
        t_ring();
        t_comb();
        results();
    end
    // the sequence needs well under 1000 cycles
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            results();
        end
    end
endmodule : testbench
